// ==== verilog/lsm_pkg.sv ====
// Purpose: Shared constants and types for the list sequence memory.
// Assumes: 100 MHz system clock; numbers carried as mantissa and exponent.
// Notes:   A number is mant * 10^expo, matching the host's text format.
package lsm_pkg;

  localparam int          LOC_COUNT      = 40;
  localparam int          LOC_W          = 6;
  localparam int          HOLD_W         = 15;
  localparam int          MANT_W         = 16;
  localparam int          EXP_W          = 4;
  localparam logic [5:0]  LOC_FIRST      = 6'h01;
  localparam logic [5:0]  LOC_LAST       = 6'h28;
  localparam logic [5:0]  LINK_END       = 6'h00;
  localparam logic [14:0] HOLD_SKIP      = 15'h0000;
  localparam logic [14:0] HOLD_MAX       = 15'h7530;
  localparam logic [15:0] ERR_DATA_RANGE = 16'hFF22;

  // Scaling of incoming numbers to internal integers (powers of ten)
  localparam int          SCALE_LEVEL    = 3;
  localparam int          SCALE_HOLD     = 2;
  localparam int          SCALE_INT      = 0;
  localparam logic signed [3:0] EXP_HOLD = 4'hE;
  localparam logic signed [3:0] EXP_INT  = 4'h0;

  // Hold time is kept in units of 10 ms
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          HOLD_UNIT_NS   = 10_000_000;
  localparam int          HOLD_UNIT_CYC  = HOLD_UNIT_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic        [MANT_W-1:0] mant;
    logic signed [EXP_W-1:0]  expo;
  } lsm_num_t;

  typedef enum logic [4:0] {
    CMD_NOP          = 5'h00,
    CMD_PTR_SET      = 5'h01,
    CMD_PTR_GET      = 5'h02,
    CMD_CURR_SET     = 5'h03,
    CMD_CURR_GET     = 5'h04,
    CMD_CTRIP_SET    = 5'h05,
    CMD_CTRIP_GET    = 5'h06,
    CMD_VOLT_SET     = 5'h07,
    CMD_VOLT_GET     = 5'h08,
    CMD_VTRIP_SET    = 5'h09,
    CMD_VTRIP_GET    = 5'h0A,
    CMD_HOLD_SET     = 5'h0B,
    CMD_HOLD_GET     = 5'h0C,
    CMD_LINK_SET     = 5'h0D,
    CMD_LINK_GET     = 5'h0E,
    CMD_FIRST_SET    = 5'h0F,
    CMD_FIRST_GET    = 5'h10,
    CMD_RUN          = 5'h11,
    CMD_STOP         = 5'h12,
    CMD_RUN_GET      = 5'h13,
    CMD_DEV_RESET    = 5'h14
  } lsm_cmd_t;

  typedef struct packed {
    lsm_cmd_t code;
    lsm_num_t arg;
  } lsm_req_t;

  typedef struct packed {
    lsm_num_t volt;
    lsm_num_t curr;
    lsm_num_t vtrip;
    lsm_num_t ctrip;
  } lsm_step_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ENTER = 4'h2,
    ST_HOLD  = 4'h4,
    ST_ADV   = 4'h8
  } lsm_state_t;

endpackage : lsm_pkg

// ==== verilog/lsm_hold_timer.sv ====
// Purpose: Counts a step hold time in 10 ms units, then pulses done.
// Assumes: start and abort come from logic on clk_sys.
// Notes:   A hold of zero is never started; the caller skips it.
`timescale 1ns/1ps
module lsm_hold_timer #(
  parameter int TICK_CYC = lsm_pkg::HOLD_UNIT_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic                      start,
  input  wire logic                      abort,
  input  wire logic [lsm_pkg::HOLD_W-1:0] hold,
  output logic                           done
);
  import lsm_pkg::*;

  localparam int PRE_W = $clog2(TICK_CYC + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
  localparam logic [HOLD_W-1:0] REM_LAST = HOLD_W'(1);

  initial
  begin
    if (TICK_CYC < 1)
      $error("lsm_hold_timer: TICK_CYC must be at least 1");
  end

  logic              busy_r;
  logic [PRE_W-1:0]  pre_r;
  logic [HOLD_W-1:0] rem_r;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy_r <= 1'b0;
      pre_r  <= '0;
      rem_r  <= '0;
      done   <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
        busy_r <= 1'b0;
      else if (start)
      begin
        busy_r <= 1'b1;
        pre_r  <= '0;
        rem_r  <= hold;
      end
      else if (busy_r)
      begin
        if (pre_r == PRE_LAST)
        begin
          pre_r <= '0;
          if (rem_r == REM_LAST)
          begin
            busy_r <= 1'b0;
            done   <= 1'b1;
          end
          else
            rem_r <= rem_r - REM_LAST;
        end
        else
          pre_r <= pre_r + PRE_W'(1);
      end
    end
  end

endmodule : lsm_hold_timer

// ==== verilog/lsm_list_sequence_memory.sv ====
// Purpose: Command-driven 40-location step table with a chained sequencer.
// Assumes: Host parser delivers decoded commands on clk_sys, one per cycle.
// Notes:   Table, pointer and first location have no reset: they model
//          non-volatile storage and keep their contents across rst_b.
`timescale 1ns/1ps

// Notes on behaviour
// - Current level set writes the value into the pointed location.
// - Out-of-range current or trip values are refused and post error -222.
// - Table contents and pointer survive reset and power cycling.
// - Current level query returns the pointed location's stored value.
// - Current trip set writes the value into the pointed location.
// - Current trip query returns the pointed location's stored value.
// - Hold time set stores 0 to 300 seconds for the pointed location.
// - A location with zero hold time is skipped and not applied.
// - Hold time query returns the pointed location's stored duration.
// - Pointer select takes 1 to 40 and targets later set and query.
// - Pointer query returns the selected location, 1 to 40.
// - Successor link set stores 0 to 40 in the pointed location.
// - A successor link of zero ends the chain and stops execution.
// - Successor link query returns the pointed location's link.
// - After a hold expires the run moves to the linked location.
// - Levels travel as decimal mantissa with exponent both ways.
// - First location set stores 1 to 40 as the run's start.
// - RUN starts, STOP halts, device reset aborts a running sequence.
// - Voltage level set writes the pointed location, -222 if out of range.
// - Run state query returns 1 while running and 0 when stopped.
module lsm_list_sequence_memory #(
  parameter int          HOLD_UNIT_CYCLES = lsm_pkg::HOLD_UNIT_CYC,
  parameter logic [31:0] VOLT_MAX_MILLI   = 32'h0000_EA60,
  parameter logic [31:0] CURR_MAX_MILLI   = 32'h0000_2710
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst_b,
  input  wire logic                      req_valid,
  input  wire lsm_pkg::lsm_req_t         req,
  output logic                           resp_valid,
  output lsm_pkg::lsm_num_t              resp_num,
  output logic                           err_valid,
  output logic [15:0]                    err_code,
  output logic                           run_active,
  output logic                           step_apply,
  output lsm_pkg::lsm_step_t             step_now,
  output logic [lsm_pkg::LOC_W-1:0]      step_location
);
  import lsm_pkg::*;

  initial
  begin
    if (HOLD_UNIT_CYCLES < 1)
      $error("lsm: HOLD_UNIT_CYCLES must be at least 1");
    if (VOLT_MAX_MILLI == 32'h0 || CURR_MAX_MILLI == 32'h0)
      $error("lsm: level limits must be above zero");
  end

  localparam logic [31:0] LIMIT_ALL  = 32'hFFFF_FFFF;
  localparam logic [LOC_W-1:0] ONE_L = LOC_W'(1);

  // Scale mant * 10^expo by 10^shift to an integer; saturates when huge
  function automatic logic [31:0] to_scaled(lsm_num_t v, int shift);
    int          e;
    logic [47:0] acc;
    e   = int'(v.expo) + shift;
    acc = 48'(v.mant);
    for (int i = 0; i < 8; i++)
    begin
      if (i < e)
        acc = acc * 48'd10;
      else if (i < -e)
        acc = acc / 48'd10;
    end
    if (e > 5 || acc > 48'(LIMIT_ALL))
      to_scaled = LIMIT_ALL;
    else
      to_scaled = acc[31:0];
  endfunction : to_scaled

  // Non-volatile step table
  lsm_num_t         volt_mem  [0:LOC_COUNT-1];
  lsm_num_t         curr_mem  [0:LOC_COUNT-1];
  lsm_num_t         vtrip_mem [0:LOC_COUNT-1];
  lsm_num_t         ctrip_mem [0:LOC_COUNT-1];
  logic [HOLD_W-1:0] hold_mem [0:LOC_COUNT-1];
  logic [LOC_W-1:0] link_mem  [0:LOC_COUNT-1];
  logic [LOC_W-1:0] ptr_r;
  logic [LOC_W-1:0] first_r;

  lsm_state_t       state_r;
  logic [LOC_W-1:0] cur_r;
  logic [LOC_W-1:0] skip_r;
  logic             tmr_start;
  logic             tmr_abort;
  logic             tmr_done;

  logic [31:0]      arg_level;
  logic [31:0]      arg_hold;
  logic [31:0]      arg_int;
  logic [LOC_W-1:0] ptr_a;
  logic [LOC_W-1:0] cur_a;
  logic             int_loc_ok;
  logic             int_link_ok;
  logic             hold_ok;
  logic             volt_ok;
  logic             curr_ok;
  logic             is_set;
  logic             arg_ok;
  logic             stop_req;
  logic             run_req;

  always_comb
  begin
    arg_level   = to_scaled(req.arg, SCALE_LEVEL);
    arg_hold    = to_scaled(req.arg, SCALE_HOLD);
    arg_int     = to_scaled(req.arg, SCALE_INT);
    ptr_a       = ptr_r - ONE_L;
    cur_a       = cur_r - ONE_L;
    int_loc_ok  = arg_int >= 32'(LOC_FIRST) && arg_int <= 32'(LOC_LAST);
    int_link_ok = arg_int <= 32'(LOC_LAST);
    hold_ok     = arg_hold <= 32'(HOLD_MAX);
    volt_ok     = arg_level <= VOLT_MAX_MILLI;
    curr_ok     = arg_level <= CURR_MAX_MILLI;
    is_set      = 1'b1;
    arg_ok      = 1'b1;
    case (req.code)
      CMD_PTR_SET, CMD_FIRST_SET: arg_ok = int_loc_ok;
      CMD_LINK_SET:               arg_ok = int_link_ok;
      CMD_HOLD_SET:               arg_ok = hold_ok;
      CMD_VOLT_SET, CMD_VTRIP_SET: arg_ok = volt_ok;
      CMD_CURR_SET, CMD_CTRIP_SET: arg_ok = curr_ok;
      default:                    is_set = 1'b0;
    endcase
    stop_req = req_valid
               && (req.code == CMD_STOP || req.code == CMD_DEV_RESET);
    run_req  = req_valid && req.code == CMD_RUN;
  end

  // Table writes; refused values leave storage untouched
  always_ff @(posedge clk_sys)
  begin
    if (req_valid && is_set && arg_ok)
    begin
      case (req.code)
        CMD_PTR_SET:   ptr_r <= arg_int[LOC_W-1:0];
        CMD_FIRST_SET: first_r <= arg_int[LOC_W-1:0];
        CMD_CURR_SET:  curr_mem[ptr_a] <= req.arg;
        CMD_CTRIP_SET: ctrip_mem[ptr_a] <= req.arg;
        CMD_VOLT_SET:  volt_mem[ptr_a] <= req.arg;
        CMD_VTRIP_SET: vtrip_mem[ptr_a] <= req.arg;
        CMD_HOLD_SET:  hold_mem[ptr_a] <= arg_hold[HOLD_W-1:0];
        CMD_LINK_SET:  link_mem[ptr_a] <= arg_int[LOC_W-1:0];
        default:       ;
      endcase
    end
  end

  // Range errors
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_valid <= 1'b0;
      err_code  <= 16'h0000;
    end
    else
    begin
      err_valid <= req_valid && is_set && !arg_ok;
      if (req_valid && is_set && !arg_ok)
        err_code <= ERR_DATA_RANGE;
    end
  end

  // Query answers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      resp_valid <= 1'b0;
      resp_num   <= '0;
    end
    else
    begin
      resp_valid <= 1'b0;
      if (req_valid)
      begin
        resp_valid <= 1'b1;
        case (req.code)
          CMD_PTR_GET:   resp_num <= '{MANT_W'(ptr_r), EXP_INT};
          CMD_FIRST_GET: resp_num <= '{MANT_W'(first_r), EXP_INT};
          CMD_CURR_GET:  resp_num <= curr_mem[ptr_a];
          CMD_CTRIP_GET: resp_num <= ctrip_mem[ptr_a];
          CMD_VOLT_GET:  resp_num <= volt_mem[ptr_a];
          CMD_VTRIP_GET: resp_num <= vtrip_mem[ptr_a];
          CMD_HOLD_GET:  resp_num <= '{MANT_W'(hold_mem[ptr_a]),
                                       EXP_HOLD};
          CMD_LINK_GET:  resp_num <= '{MANT_W'(link_mem[ptr_a]),
                                       EXP_INT};
          CMD_RUN_GET:   resp_num <= '{MANT_W'(run_active), EXP_INT};
          default:       resp_valid <= 1'b0;
        endcase
      end
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r    <= ST_IDLE;
      cur_r      <= '0;
      skip_r     <= '0;
      run_active <= 1'b0;
    end
    else if (stop_req)
    begin
      state_r    <= ST_IDLE;
      run_active <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (run_req)
          begin
            state_r    <= ST_ENTER;
            cur_r      <= first_r;
            skip_r     <= '0;
            run_active <= 1'b1;
          end
        end
        ST_ENTER:
        begin
          if (cur_r < LOC_FIRST || cur_r > LOC_LAST
              || skip_r == LOC_W'(LOC_COUNT))
          begin
            state_r    <= ST_IDLE;
            run_active <= 1'b0;
          end
          else if (hold_mem[cur_a] == HOLD_SKIP)
          begin
            cur_r  <= link_mem[cur_a];
            skip_r <= skip_r + ONE_L;
            if (link_mem[cur_a] == LINK_END)
            begin
              state_r    <= ST_IDLE;
              run_active <= 1'b0;
            end
          end
          else
            state_r <= ST_HOLD;
        end
        ST_HOLD:
        begin
          if (tmr_done)
            state_r <= ST_ADV;
        end
        default:
        begin
          if (link_mem[cur_a] == LINK_END)
          begin
            state_r    <= ST_IDLE;
            run_active <= 1'b0;
          end
          else
          begin
            state_r <= ST_ENTER;
            cur_r   <= link_mem[cur_a];
            skip_r  <= '0;
          end
        end
      endcase
    end
  end

  // Applied levels: one update per entered location with a nonzero hold
  always_comb
  begin
    tmr_start = !stop_req && state_r == ST_ENTER
                && cur_r >= LOC_FIRST && cur_r <= LOC_LAST
                && skip_r != LOC_W'(LOC_COUNT)
                && hold_mem[cur_a] != HOLD_SKIP;
    tmr_abort = stop_req;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step_apply    <= 1'b0;
      step_now      <= '0;
      step_location <= '0;
    end
    else
    begin
      step_apply <= tmr_start;
      if (tmr_start)
      begin
        step_now      <= '{volt_mem[cur_a], curr_mem[cur_a],
                           vtrip_mem[cur_a], ctrip_mem[cur_a]};
        step_location <= cur_r;
      end
    end
  end

  lsm_hold_timer #(
    .TICK_CYC (HOLD_UNIT_CYCLES)
  ) u_hold_timer (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .start   (tmr_start),
    .abort   (tmr_abort),
    .hold    (hold_mem[cur_a]),
    .done    (tmr_done)
  );

endmodule : lsm_list_sequence_memory

// ==== test/lsm_checker_properties.sv ====
// Purpose: Port-level properties of the list sequence memory.
// Assumes: One clock domain; reset asynchronous, active low.
// Notes:   Attached by bind from the testbench top file.
`timescale 1ns/1ps
module lsm_checker #(
  parameter logic [31:0] CURR_MAX_MILLI = 32'h0000_2710
) (
  input wire logic               clk_sys,
  input wire logic               rst_b,
  input wire logic               req_valid,
  input wire lsm_pkg::lsm_req_t  req,
  input wire logic               resp_valid,
  input wire lsm_pkg::lsm_num_t  resp_num,
  input wire logic               err_valid,
  input wire logic [15:0]        err_code,
  input wire logic               run_active,
  input wire logic               step_apply,
  input wire lsm_pkg::lsm_step_t step_now,
  input wire logic [5:0]         step_location
);
  import lsm_pkg::*;
  logic is_query;
  assign is_query = req.code inside {CMD_PTR_GET, CMD_CURR_GET, CMD_CTRIP_GET,
    CMD_VOLT_GET, CMD_VTRIP_GET, CMD_HOLD_GET, CMD_LINK_GET, CMD_FIRST_GET,
    CMD_RUN_GET};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_query_answers: assert property (req_valid && is_query |=> resp_valid)
    else $error("query gave no answer");
  a_no_stray_answer: assert property (resp_valid |-> $past(req_valid && is_query))
    else $error("answer without a query");
  a_ptr_refused: assert property (req_valid && req.code == CMD_PTR_SET &&
    req.arg.expo == EXP_INT && (req.arg.mant == 16'h0000 || req.arg.mant > 16'h0028)
    |=> err_valid && err_code == ERR_DATA_RANGE)
    else $error("bad pointer not refused");
  a_link_refused: assert property (req_valid && req.code == CMD_LINK_SET &&
    req.arg.expo == EXP_INT && req.arg.mant > 16'h0028 |=> err_valid)
    else $error("bad link not refused");
  a_hold_refused: assert property (req_valid && req.code == CMD_HOLD_SET &&
    req.arg.expo == EXP_HOLD && req.arg.mant > 16'h7530 |=> err_valid)
    else $error("bad hold not refused");
  a_curr_refused: assert property (req_valid &&
    req.code inside {CMD_CURR_SET, CMD_CTRIP_SET} && req.arg.expo == EXP_INT &&
    32'(req.arg.mant) * 32'd1000 > CURR_MAX_MILLI |=> err_valid)
    else $error("bad current not refused");
  a_run_starts: assert property (req_valid && req.code == CMD_RUN && !run_active
    |=> run_active)
    else $error("run did not start");
  a_stop_halts: assert property (req_valid && req.code == CMD_STOP
    |=> !run_active ##1 !step_apply [*3])
    else $error("stop did not halt");
  a_reset_aborts: assert property (req_valid && req.code == CMD_DEV_RESET
    |=> !run_active)
    else $error("device reset did not abort");
  a_run_state_read: assert property (req_valid && req.code == CMD_RUN_GET |=>
    resp_num.mant == {15'h0000, $past(run_active)} && resp_num.expo == EXP_INT)
    else $error("run state answer wrong");
  a_apply_spacing: assert property (step_apply |-> run_active ##1 !step_apply [*3])
    else $error("applies too close");
  a_apply_location: assert property (step_apply |-> step_location >= LOC_FIRST &&
    step_location <= LOC_LAST)
    else $error("applied location out of range");
endmodule : lsm_checker

// ==== test/lsm_host_model.sv ====
// Purpose: Host controller model issuing decoded commands.
// Assumes: Commands change at the falling edge, one per two cycles.
// Notes:   Answer flags are sampled at the falling edge after the command is taken.
`timescale 1ns/1ps
module lsm_host_model (
  input wire logic               clk_sys,
  output lsm_pkg::lsm_req_t      req,
  output logic                   req_valid,
  input wire logic               resp_valid,
  input wire lsm_pkg::lsm_num_t  resp_num,
  input wire logic               err_valid
);
  import lsm_pkg::*;
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  // Values go out as mantissa and power-of-ten exponent
  task automatic send(input lsm_cmd_t c, input logic [15:0] m,
    input logic [3:0] e, output logic rv, output logic ev, output lsm_num_t n);
    @(negedge clk_sys);
    req = {c, m, e};
    req_valid = 1'b1;
    @(negedge clk_sys);
    rv = resp_valid;
    ev = err_valid;
    n = resp_num;
    req_valid = 1'b0;
  endtask : send
endmodule : lsm_host_model

// ==== test/lsm_testbench.sv ====
// Purpose: Self-checking bench for the list sequence memory.
// Assumes: Hold unit shortened to 4 cycles.
// Notes:   Each value stored by t_table is queried right after it is written; location 3's link is rewritten after the first run.
`timescale 1ns/1ps
module testbench;
  import lsm_pkg::*;
  logic      clk_sys;
  logic      rst_b;
  logic      req_valid;
  lsm_req_t  req;
  logic      resp_valid;
  lsm_num_t  resp_num;
  logic      err_valid;
  logic [15:0] err_code;
  logic      run_active;
  logic      step_apply;
  lsm_step_t step_now;
  logic [5:0] step_location;
  logic      rv;
  logic      ev;
  lsm_num_t  rn;
  int        mismatches = 0;
  int        check_count = 0;

  lsm_list_sequence_memory #(.HOLD_UNIT_CYCLES(4)) dut (.clk_sys(clk_sys),
    .rst_b(rst_b), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp_num(resp_num), .err_valid(err_valid), .err_code(err_code),
    .run_active(run_active), .step_apply(step_apply), .step_now(step_now),
    .step_location(step_location));
  lsm_host_model u_host (.clk_sys(clk_sys), .req(req), .req_valid(req_valid),
    .resp_valid(resp_valid), .resp_num(resp_num), .err_valid(err_valid));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic lsm_num_t n(logic [15:0] m, logic [3:0] e);
    return {m, e};
  endfunction : n
  task automatic chk_bit(logic got, logic exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_num(lsm_num_t got, lsm_num_t exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_num
  task automatic chk_val(logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic cmd(lsm_cmd_t c, logic [15:0] m, logic [3:0] e);
    u_host.send(c, m, e, rv, ev, rn);
  endtask : cmd
  task automatic qry(lsm_cmd_t c, lsm_num_t exp);
    cmd(c, 16'h0000, 4'h0);
    chk_bit(rv, 1'b1);
    chk_num(rn, exp);
  endtask : qry
  task automatic setloc(logic [15:0] l, logic [15:0] h, logic [15:0] k,
    logic [15:0] c);
    cmd(CMD_PTR_SET, l, 4'h0);
    cmd(CMD_HOLD_SET, h, 4'hE);
    cmd(CMD_LINK_SET, k, 4'h0);
    cmd(CMD_CURR_SET, c, 4'hD);
    cmd(CMD_VOLT_SET, c, 4'hE);
  endtask : setloc
  task automatic wait_apply(logic [5:0] loc, logic [15:0] c);
    for (int i = 0; i < 100 && step_apply !== 1'b1; i++) @(negedge clk_sys);
    chk_bit(step_apply, 1'b1);
    chk_val(16'(step_location), 16'(loc));
    chk_num(step_now.curr, n(c, 4'hD));
    chk_num(step_now.volt, n(c, 4'hE));
  endtask : wait_apply

  task automatic t_table;
    cmd(CMD_PTR_SET, 16'h0015, 4'h0);
    qry(CMD_PTR_GET, n(16'h0015, 4'h0));
    cmd(CMD_CURR_SET, 16'h00EB, 4'hD);
    qry(CMD_CURR_GET, n(16'h00EB, 4'hD));
    cmd(CMD_CTRIP_SET, 16'h0043, 4'hF);
    qry(CMD_CTRIP_GET, n(16'h0043, 4'hF));
    cmd(CMD_HOLD_SET, 16'h0006, 4'hF);
    qry(CMD_HOLD_GET, n(16'h003C, 4'hE));
    cmd(CMD_LINK_SET, 16'h0027, 4'h0);
    qry(CMD_LINK_GET, n(16'h0027, 4'h0));
    cmd(CMD_VOLT_SET, 16'h0113, 4'hF);
    qry(CMD_VOLT_GET, n(16'h0113, 4'hF));
    cmd(CMD_VTRIP_SET, 16'h0115, 4'hF);
    qry(CMD_VTRIP_GET, n(16'h0115, 4'hF));
  endtask : t_table
  task automatic t_range;
    lsm_cmd_t    c[7] = '{CMD_PTR_SET, CMD_PTR_SET, CMD_CURR_SET, CMD_CTRIP_SET,
                          CMD_HOLD_SET, CMD_LINK_SET, CMD_VOLT_SET};
    logic [15:0] m[7] = '{16'h0029, 16'h0000, 16'h000B, 16'h0065, 16'h7531,
                          16'h0029, 16'h0259};
    logic [3:0]  e[7] = '{4'h0, 4'h0, 4'h0, 4'hF, 4'hE, 4'h0, 4'hF};
    for (int i = 0; i < 7; i++)
    begin
      cmd(c[i], m[i], e[i]);
      chk_bit(ev, 1'b1);
      chk_val(err_code, 16'hFF22);
    end
    qry(CMD_PTR_GET, n(16'h0015, 4'h0));
    qry(CMD_CURR_GET, n(16'h00EB, 4'hD));
    qry(CMD_CTRIP_GET, n(16'h0043, 4'hF));
    qry(CMD_HOLD_GET, n(16'h003C, 4'hE));
    qry(CMD_LINK_GET, n(16'h0027, 4'h0));
    qry(CMD_VOLT_GET, n(16'h0113, 4'hF));
  endtask : t_range
  task automatic t_run;
    setloc(16'h0001, 16'h0001, 16'h0002, 16'h0064);
    setloc(16'h0002, 16'h0000, 16'h0003, 16'h0064);
    setloc(16'h0003, 16'h0001, 16'h0000, 16'h00C8);
    cmd(CMD_FIRST_SET, 16'h0001, 4'h0);
    qry(CMD_FIRST_GET, n(16'h0001, 4'h0));
    cmd(CMD_RUN, 16'h0000, 4'h0);
    chk_bit(run_active, 1'b1);
    wait_apply(6'h01, 16'h0064);
    qry(CMD_RUN_GET, n(16'h0001, 4'h0));
    wait_apply(6'h03, 16'h00C8);
    repeat (20) @(negedge clk_sys);
    chk_bit(run_active, 1'b0);
    qry(CMD_RUN_GET, n(16'h0000, 4'h0));
  endtask : t_run
  task automatic t_stop;
    lsm_cmd_t ab[2] = '{CMD_STOP, CMD_DEV_RESET};
    logic     seen;
    cmd(CMD_PTR_SET, 16'h0003, 4'h0);
    cmd(CMD_LINK_SET, 16'h0001, 4'h0);
    for (int i = 0; i < 2; i++)
    begin
      cmd(CMD_RUN, 16'h0000, 4'h0);
      wait_apply(6'h01, 16'h0064);
      cmd(ab[i], 16'h0000, 4'h0);
      chk_bit(run_active, 1'b0);
      seen = 1'b0;
      repeat (20) @(negedge clk_sys) seen |= step_apply;
      chk_bit(seen, 1'b0);
    end
  endtask : t_stop
  task automatic t_keep;
    @(negedge clk_sys);
    rst_b = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    qry(CMD_PTR_GET, n(16'h0003, 4'h0));
    qry(CMD_LINK_GET, n(16'h0001, 4'h0));
    qry(CMD_CURR_GET, n(16'h00C8, 4'hD));
  endtask : t_keep

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    #100us;
    mismatches++;
    end_of_test();
  end
  initial
  begin
    rst_b = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    t_table();
    t_range();
    t_run();
    t_stop();
    t_keep();
    end_of_test();
  end
endmodule : testbench

bind lsm_list_sequence_memory lsm_checker #(.CURR_MAX_MILLI(CURR_MAX_MILLI))
  u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req(req),
  .resp_valid(resp_valid), .resp_num(resp_num), .err_valid(err_valid),
  .err_code(err_code), .run_active(run_active), .step_apply(step_apply),
  .step_now(step_now), .step_location(step_location));
